/* bench/sswd_host.sv */
// Host microcontroller model that drives the register port and answers the watchdog.
`timescale 1ns/1ns
module sswd_host (
	input  wire logic                        i_mclk,
	output logic      [sswd_pkg::ADDR_W-1:0] o_addr,
	output logic      [sswd_pkg::DATA_W-1:0] o_wdata,
	output logic                             o_wr,
	output logic                             o_rd
);
	import sswd_pkg::*;
	// ==========================================
	// Model state
	logic [7:0] exp_q[$];
	logic [7:0] chal = 8'hB2;
	initial begin
		o_addr = 4'h0;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	// ==========================================
	// Accesses
	// The host keeps its own copy of the sequence, so a wrong tap shows up.
	function automatic logic [7:0] step(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : step
	// Released lines show the inverse, so a stale value is never mistaken for a drive.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_mclk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
		@(posedge i_mclk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_mclk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		@(posedge i_mclk);
	endtask : rd
	task automatic seed(input logic [7:0] s);
		wr(ADDR_CHALLENGE, s);
		chal = s;
	endtask : seed
	// A slow host waits longer before answering; a nonzero flip spoils the answer.
	task automatic answer(input logic [7:0] flip, input int wait_cyc);
		repeat (wait_cyc) @(posedge i_mclk);
		wr(ADDR_ANSWER, ~chal ^ flip);
		if (flip == 8'h00) begin
			chal = step(chal);
		end
	endtask : answer
endmodule : sswd_host

/* bench/test_sswd_top.sv */
// Self-checking testbench of the safety state machine with challenge watchdog.
`timescale 1ns/1ns
module test_sswd_top;
	import sswd_pkg::*;
	// ==========================================
	// Signals and counters
	logic              i_mclk;
	logic              i_rst;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              wr;
	logic              rd;
	logic [DATA_W-1:0] o_rdata;
	logic              i_key;
	logic              i_debug;
	logic              i_ext_rst_n;
	logic              i_fault;
	logic              o_reset_out_n;
	logic              o_failsafe_out_n;
	logic              o_irq_out_n;
	logic              o_regs_on;
	logic              rd_seen = 1'b0;
	int                err_total = 0;
	int                n_compared = 0;
	int                cycles = 0;
	int                r;
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	// Short ticks keep the run small: one tick is 10 cycles, the stuck limit 40 ticks.
	sswd_top #(.TICK_CYCLES(10), .STUCK_TICKS(40)) u_sswd_top (
		.i_mclk           (i_mclk),
		.i_rst            (i_rst),
		.i_addr           (addr),
		.i_wdata          (wdata),
		.i_wr             (wr),
		.i_rd             (rd),
		.o_rdata          (o_rdata),
		.i_key            (i_key),
		.i_debug          (i_debug),
		.i_ext_rst_n      (i_ext_rst_n),
		.i_fault          (i_fault),
		.o_reset_out_n    (o_reset_out_n),
		.o_failsafe_out_n (o_failsafe_out_n),
		.o_irq_out_n      (o_irq_out_n),
		.o_regs_on        (o_regs_on)
	);
	sswd_host u_sswd_host (
		.i_mclk  (i_mclk),
		.o_addr  (addr),
		.o_wdata (wdata),
		.o_wr    (wr),
		.o_rd    (rd)
	);
	// ==========================================
	// Checking helpers
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	function automatic logic pick(input int w);
		case (w)
			0: return o_reset_out_n;
			1: return o_regs_on;
			default: return o_irq_out_n;
		endcase
	endfunction : pick
	// Bounded wait for a level; the cycle count must land inside lo..lim-1.
	task automatic wait_lvl(input int w, input logic v, input int lim, input int lo);
		int n;
		n = 0;
		while (pick(w) !== v && n < lim) begin
			@(posedge i_mclk);
			n++;
		end
		check(8'(n >= lo && n < lim), 8'h01);
	endtask : wait_lvl
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	// ==========================================
	// Read data watcher and hang limit
	always @(posedge i_mclk) begin
		if (rd_seen) begin
			check(o_rdata, u_sswd_host.exp_q.pop_front());
		end
		rd_seen <= rd;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_total++;
			give_verdict();
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		i_rst = 1'b1;
		i_key = 1'b1;
		i_debug = 1'b0;
		i_ext_rst_n = 1'b1;
		i_fault = 1'b0;
		r = $urandom(81794);
		repeat (2) @(posedge i_mclk);
		check({4'h0, o_reset_out_n, o_failsafe_out_n, o_irq_out_n, o_regs_on}, 8'h03);
		i_rst <= 1'b0;
		wait_lvl(0, 1'b1, 400, 300);
		u_sswd_host.rd(ADDR_CHALLENGE, 8'hB2);
		u_sswd_host.rd(ADDR_STATUS, 8'h2C);
		u_sswd_host.wr(ADDR_RST_DLY, 8'h00);
		u_sswd_host.wr(ADDR_FS_CFG2, 8'h01);
		u_sswd_host.rd(ADDR_RST_DLY, 8'h00);
		u_sswd_host.rd(ADDR_FS_CFG2, 8'h01);
		u_sswd_host.rd(4'h9, 8'h00);
		for (int s = 0; s < 16; s++) begin
			u_sswd_host.wr(ADDR_WINDOW, 8'(s));
			u_sswd_host.rd(ADDR_WINDOW, 8'((s < 15) ? s : 14));
		end
		u_sswd_host.wr(ADDR_WINDOW, 8'h02);
		u_sswd_host.answer(8'h00, 4);
		u_sswd_host.rd(ADDR_STATUS, 8'h28);
		u_sswd_host.rd(ADDR_CHALLENGE, u_sswd_host.chal);
		u_sswd_host.wr(ADDR_RST_DLY, 8'h03);
		u_sswd_host.rd(ADDR_RST_DLY, 8'h00);
		u_sswd_host.wr(ADDR_WINDOW, 8'h01);
		u_sswd_host.rd(ADDR_WINDOW, 8'h01);
		u_sswd_host.wr(ADDR_WINDOW, 8'h02);
		u_sswd_host.answer(8'h00, 30);
		repeat (6) u_sswd_host.answer(8'h00, 40);
		u_sswd_host.rd(ADDR_STATUS, 8'h08);
		check({7'h00, o_failsafe_out_n}, 8'h01);
		u_sswd_host.answer(8'($urandom_range(255, 1)), 40);
		u_sswd_host.rd(ADDR_COUNTERS, 8'h82);
		check({7'h00, o_irq_out_n}, 8'h00);
		u_sswd_host.rd(ADDR_CHALLENGE, u_sswd_host.chal);
		u_sswd_host.answer(8'h00, 36);
		u_sswd_host.rd(ADDR_ANSWER, 8'h00);
		u_sswd_host.rd(ADDR_COUNTERS, 8'h83);
		wait_lvl(0, 1'b0, 200, 80);
		wait_lvl(0, 1'b1, 40, 10);
		check({7'h00, o_failsafe_out_n}, 8'h00);
		i_ext_rst_n <= 1'b0;
		wait_lvl(1, 1'b0, 30, 0);
		i_ext_rst_n <= 1'b1;
		check({6'h00, o_reset_out_n, o_failsafe_out_n}, 8'h00);
		i_key <= 1'b0;
		repeat (6) @(posedge i_mclk);
		check({7'h00, o_regs_on}, 8'h00);
		i_key <= 1'b1;
		wait_lvl(1, 1'b1, 10, 0);
		wait_lvl(0, 1'b1, 400, 300);
		u_sswd_host.rd(ADDR_STATUS, 8'h2C);
		u_sswd_host.rd(ADDR_FS_CFG2, 8'h00);
		u_sswd_host.seed(8'($urandom));
		u_sswd_host.rd(ADDR_CHALLENGE, u_sswd_host.chal);
		u_sswd_host.wr(ADDR_WINDOW, 8'h12);
		u_sswd_host.rd(ADDR_STATUS, 8'h2D);
		u_sswd_host.answer(8'h01, 2);
		check({6'h00, o_reset_out_n, o_irq_out_n}, 8'h02);
		u_sswd_host.rd(ADDR_STATUS, 8'h2D);
		u_sswd_host.wr(ADDR_SUP_CFG2, 8'h01);
		u_sswd_host.rd(ADDR_SUP_CFG2, 8'h01);
		// With the stuck timer off, a held fault keeps reset low without going deep.
		i_fault <= 1'b1;
		repeat (450) @(posedge i_mclk);
		check({6'h00, o_reset_out_n, o_regs_on}, 8'h01);
		i_fault <= 1'b0;
		wait_lvl(0, 1'b1, 20, 3);
		u_sswd_host.wr(ADDR_SUP_CFG2, 8'h00);
		i_fault <= 1'b1;
		wait_lvl(1, 1'b0, 500, 300);
		i_key <= 1'b0;
		repeat (6) @(posedge i_mclk);
		i_key <= 1'b1;
		wait_lvl(1, 1'b1, 10, 0);
		wait_lvl(1, 1'b0, 500, 300);
		give_verdict();
	end
endmodule : test_sswd_top

/* design/sswd_pkg.sv */
// Constants, types and helpers of the safety state machine with challenge watchdog.
package sswd_pkg;

	// ==========================================================
	// Register map and bus
	localparam int          ADDR_W          = 4;
	localparam int          DATA_W          = 8;
	localparam logic [3:0]  ADDR_RST_DLY    = 4'h0;
	localparam logic [3:0]  ADDR_FS_CFG2    = 4'h1;
	localparam logic [3:0]  ADDR_SUP_CFG2   = 4'h2;
	localparam logic [3:0]  ADDR_WINDOW     = 4'h3;
	localparam logic [3:0]  ADDR_CHALLENGE  = 4'h4;
	localparam logic [3:0]  ADDR_ANSWER     = 4'h5;
	localparam logic [3:0]  ADDR_STATUS     = 4'h6;
	localparam logic [3:0]  ADDR_COUNTERS   = 4'h7;

	// ==========================================================
	// Reset values and limits
	localparam logic [7:0]  LFSR_RESET      = 8'hB2;
	localparam logic [3:0]  WIN_SEL_RESET   = 4'h2;
	localparam logic [3:0]  WIN_SEL_BAD     = 4'hF;
	localparam logic [1:0]  RST_DLY_RESET   = 2'h1;
	localparam logic [2:0]  RST_ERR_RESET   = 3'h1;
	localparam logic [2:0]  RST_ERR_MAX     = 3'h7;
	localparam logic [3:0]  WD_ERR_LIMIT    = 4'h6;
	localparam logic [2:0]  REFRESH_LIMIT   = 3'h6;
	localparam logic [2:0]  FINAL_LONG      = 3'h6;
	localparam logic [2:0]  FINAL_SHORT     = 3'h2;
	localparam logic [2:0]  INTER_LONG      = 3'h3;
	localparam logic [2:0]  INTER_SHORT     = 3'h1;

	// ==========================================================
	// Timing: one tick is half a millisecond
	localparam int          CLK_NS          = 10;
	localparam int          TICK_NS         = 500000;
	localparam int          TICK_CYC        = TICK_NS / CLK_NS;
	localparam int          TICKS_PER_MS    = 1000000 / TICK_NS;
	localparam int          STUCK_MS        = 8000;
	localparam int          STUCK_TK        = STUCK_MS * TICKS_PER_MS;
	localparam logic [11:0] INIT_TK         = 12'(256 * TICKS_PER_MS);
	localparam logic [11:0] POR_DLY_TK      = 12'(16 * TICKS_PER_MS);
	localparam int          IRQ_NS          = 1000;
	localparam logic [7:0]  IRQ_CYC         = 8'(IRQ_NS / CLK_NS);

	typedef enum logic [2:0] {
		ST_SELECT = 3'b000,
		ST_RST_DLY = 3'b001,
		ST_INIT = 3'b011,
		ST_RUN = 3'b010,
		ST_DEEP = 3'b110,
		ST_SLEEP = 3'b111
	} sswd_state_t;

	typedef struct packed {
		logic [1:0] rst_dly;
		logic       final_short;
		logic       stuck_dis;
		logic [3:0] win_sel;
		logic       wd_dis;
	} sswd_cfg_t;

	localparam sswd_cfg_t CFG_RESET = '{RST_DLY_RESET, 1'b0, 1'b0, WIN_SEL_RESET, 1'b0};

	// ==========================================================
	// Helpers
	function automatic logic [11:0] win_ticks(input logic [3:0] sel);
		int ms;
		unique case (sel)
			4'h0: ms = 1;
			4'h1: ms = 2;
			4'h2: ms = 3;
			4'h3: ms = 4;
			4'h4: ms = 6;
			4'h5: ms = 8;
			4'h6: ms = 12;
			4'h7: ms = 16;
			4'h8: ms = 24;
			4'h9: ms = 32;
			4'hA: ms = 64;
			4'hB: ms = 128;
			4'hC: ms = 256;
			4'hD: ms = 512;
			default: ms = 1024;
		endcase
		return 12'(ms * TICKS_PER_MS);
	endfunction : win_ticks

	function automatic logic [11:0] dly_ticks(input logic [1:0] sel);
		int ms;
		unique case (sel)
			2'h0: ms = 1;
			2'h1: ms = 8;
			2'h2: ms = 16;
			default: ms = 32;
		endcase
		return 12'(ms * TICKS_PER_MS);
	endfunction : dly_ticks

	function automatic logic [7:0] lfsr_step(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr_step

	function automatic logic [7:0] answer_of(input logic [7:0] x);
		return ~x;
	endfunction : answer_of

endpackage : sswd_pkg

/* design/sswd_top.sv */
// Safety state machine with challenge/answer windowed watchdog and reset supervision.
`timescale 1ns/1ns
module sswd_top #(
	parameter int TICK_CYCLES = sswd_pkg::TICK_CYC,
	parameter int STUCK_TICKS = sswd_pkg::STUCK_TK
) (
	input  wire logic                        i_mclk,
	input  wire logic                        i_rst,
	input  wire logic [sswd_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [sswd_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [sswd_pkg::DATA_W-1:0] o_rdata,
	input  wire logic                        i_key,
	input  wire logic                        i_debug,
	input  wire logic                        i_ext_rst_n,
	input  wire logic                        i_fault,
	output logic                             o_reset_out_n,
	output logic                             o_failsafe_out_n,
	output logic                             o_irq_out_n,
	output logic                             o_regs_on
);
	import sswd_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic       key_s;
	logic       debug_s;
	logic       ext_rst_n_s;
	logic       fault_s;

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sync1 <= 4'h6;
			sync2 <= 4'h6;
		end else begin
			sync1 <= {i_key, i_debug, i_ext_rst_n, i_fault};
			sync2 <= sync1;
		end
	end

	assign key_s       = sync2[3];
	assign debug_s     = sync2[2];
	assign ext_rst_n_s = sync2[1];
	assign fault_s     = sync2[0];

	// ==========================================================
	// Half-millisecond tick
	logic [16:0] tick_cnt;
	logic [16:0] next_tick_cnt;
	logic        tick;
	logic        next_tick;

	always_comb begin
		next_tick = (tick_cnt == 17'(TICK_CYCLES - 1));
		next_tick_cnt = next_tick ? 17'h00000 : tick_cnt + 17'h00001;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			tick_cnt <= 17'h00000;
			tick <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			tick <= next_tick;
		end
	end

	// ==========================================================
	// Safety state machine and watchdog
	sswd_state_t state;
	sswd_state_t next_state;
	sswd_cfg_t   cfg;
	sswd_cfg_t   next_cfg;
	logic        powerup;
	logic        next_powerup;
	logic        dbg_lat;
	logic        next_dbg_lat;
	logic [3:0]  win_act;
	logic [3:0]  next_win_act;
	logic [7:0]  lfsr;
	logic [7:0]  next_lfsr;
	logic [3:0]  wd_err;
	logic [3:0]  next_wd_err;
	logic [2:0]  ref_cnt;
	logic [2:0]  next_ref_cnt;
	logic [2:0]  rst_err;
	logic [2:0]  next_rst_err;
	logic [11:0] tcnt;
	logic [11:0] next_tcnt;
	logic [15:0] stk_cnt;
	logic [15:0] next_stk_cnt;
	logic [7:0]  irq_cnt;
	logic [7:0]  next_irq_cnt;
	logic [7:0]  next_rdata;
	logic        next_reset_n;
	logic        next_fs_n;
	logic        next_regs_on;

	logic        in_wd;
	logic        inhibit;
	logic        closed;
	logic        ans_hit;
	logic        ans_good;
	logic        ans_bad;
	logic        timeout;
	logic        go_reset;
	logic [11:0] full_tk;
	logic [2:0]  final_val;
	logic [2:0]  inter_val;
	logic [4:0]  err_sum;

	assign in_wd     = (state == ST_INIT) || (state == ST_RUN);
	assign inhibit   = dbg_lat | cfg.wd_dis;
	assign full_tk   = (state == ST_INIT) ? INIT_TK : win_ticks(win_act);
	assign closed    = (state == ST_RUN) && (tcnt < {1'b0, full_tk[11:1]});
	assign ans_hit   = (i_wr || i_rd) && (i_addr == ADDR_ANSWER) && in_wd;
	assign ans_good  = ans_hit && i_wr && !closed && (i_wdata == answer_of(lfsr));
	assign ans_bad   = ans_hit && !ans_good;
	assign timeout   = in_wd && tick && (tcnt == full_tk - 12'h001) && !ans_hit;
	assign final_val = cfg.final_short ? FINAL_SHORT : FINAL_LONG;
	assign inter_val = cfg.final_short ? INTER_SHORT : INTER_LONG;
	assign err_sum   = {1'b0, wd_err} + 5'h02;

	always_comb begin
		next_state = state;
		next_cfg = cfg;
		next_powerup = powerup;
		next_dbg_lat = dbg_lat;
		next_win_act = win_act;
		next_lfsr = lfsr;
		next_wd_err = wd_err;
		next_ref_cnt = ref_cnt;
		next_rst_err = rst_err;
		next_tcnt = tcnt;
		next_stk_cnt = stk_cnt;
		next_irq_cnt = (irq_cnt != 8'h00) ? irq_cnt - 8'h01 : 8'h00;
		go_reset = 1'b0;

		// Configuration writes, each limited to the phase that may change it.
		if (i_wr && state == ST_INIT) begin
			unique case (i_addr)
				ADDR_RST_DLY:   next_cfg.rst_dly = i_wdata[1:0];
				ADDR_FS_CFG2:   next_cfg.final_short = i_wdata[0];
				ADDR_SUP_CFG2:  next_cfg.stuck_dis = i_wdata[0];
				ADDR_CHALLENGE: next_lfsr = i_wdata;
				default: ;
			endcase
		end
		if (i_wr && in_wd && i_addr == ADDR_WINDOW) begin
			next_cfg.wd_dis = i_wdata[4];
			if (i_wdata[3:0] != WIN_SEL_BAD) begin
				next_cfg.win_sel = i_wdata[3:0];
			end
		end

		unique case (state)
			ST_SELECT: begin
				next_state = ST_RST_DLY;
				next_tcnt = 12'h000;
			end
			ST_RST_DLY: begin
				if (tick) begin
					if (tcnt >= (powerup ? POR_DLY_TK : dly_ticks(cfg.rst_dly)) - 12'h001) begin
						if (!fault_s && ext_rst_n_s) begin
							next_state = ST_INIT;
							next_tcnt = 12'h000;
							next_powerup = 1'b0;
							if (powerup) begin
								next_dbg_lat = debug_s;
							end
						end
					end else begin
						next_tcnt = tcnt + 12'h001;
					end
				end
			end
			ST_INIT: begin
				if (tick) begin
					next_tcnt = tcnt + 12'h001;
				end
				if (ans_good) begin
					next_state = ST_RUN;
					next_lfsr = lfsr_step(lfsr);
					next_win_act = next_cfg.win_sel;
					next_tcnt = 12'h000;
				end else if (ans_bad || timeout) begin
					next_irq_cnt = IRQ_CYC;
					next_tcnt = 12'h000;
					go_reset = !inhibit;
				end
				if (fault_s || !ext_rst_n_s) begin
					go_reset = 1'b1;
				end
			end
			ST_RUN: begin
				if (tick) begin
					next_tcnt = tcnt + 12'h001;
				end
				if (ans_good) begin
					next_lfsr = lfsr_step(lfsr);
					next_wd_err = (wd_err != 4'h0) ? wd_err - 4'h1 : 4'h0;
					next_tcnt = 12'h000;
					next_win_act = next_cfg.win_sel;
					if (ref_cnt == REFRESH_LIMIT) begin
						next_ref_cnt = 3'h0;
						next_rst_err = (rst_err != 3'h0) ? rst_err - 3'h1 : 3'h0;
					end else begin
						next_ref_cnt = ref_cnt + 3'h1;
					end
				end else if (ans_bad || timeout) begin
					next_wd_err = (err_sum >= {1'b0, WD_ERR_LIMIT}) ? WD_ERR_LIMIT : err_sum[3:0];
					next_ref_cnt = 3'h0;
					next_irq_cnt = IRQ_CYC;
					next_tcnt = 12'h000;
					next_win_act = next_cfg.win_sel;
					go_reset = !inhibit && (err_sum >= {1'b0, WD_ERR_LIMIT});
				end
				if (fault_s || !ext_rst_n_s) begin
					go_reset = 1'b1;
				end
			end
			ST_DEEP: begin
				if (!key_s) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (key_s) begin
					next_state = ST_SELECT;
					next_cfg = CFG_RESET;
					next_powerup = 1'b1;
					next_dbg_lat = 1'b0;
					next_win_act = WIN_SEL_RESET;
					next_lfsr = LFSR_RESET;
					next_wd_err = 4'h0;
					next_ref_cnt = 3'h0;
					next_rst_err = RST_ERR_RESET;
					next_tcnt = 12'h000;
					next_stk_cnt = 16'h0000;
				end
			end
			default: next_state = ST_SELECT;
		endcase

		if (go_reset) begin
			next_state = ST_RST_DLY;
			next_tcnt = 12'h000;
			next_stk_cnt = 16'h0000;
			next_wd_err = 4'h0;
			next_ref_cnt = 3'h0;
			next_rst_err = (rst_err == RST_ERR_MAX) ? RST_ERR_MAX : rst_err + 3'h1;
		end

		// The stuck timer keeps its value after release; no register reads it back, and go_reset clears it.
		if ((state == ST_SELECT || state == ST_RST_DLY) && (powerup || !cfg.stuck_dis)) begin
			if (tick) begin
				next_stk_cnt = stk_cnt + 16'h0001;
			end
			if (tick && stk_cnt >= 16'(STUCK_TICKS)) begin
				next_state = ST_DEEP;
			end
		end
		// The limit follows a same-cycle config write, so a lowered limit trips at once.
		if (next_rst_err >= (next_cfg.final_short ? FINAL_SHORT : FINAL_LONG) &&
			state != ST_SLEEP && state != ST_DEEP) begin
			next_state = ST_DEEP;
		end

		next_reset_n = (next_state == ST_INIT) || (next_state == ST_RUN);
		next_regs_on = (next_state != ST_DEEP) && (next_state != ST_SLEEP);
		next_fs_n = next_regs_on && !fault_s && (next_rst_err < inter_val) &&
			(next_rst_err == 3'h0 || state == ST_RUN || next_state == ST_RUN);

		next_rdata = 8'h00;
		if (i_rd) begin
			unique case (i_addr)
				ADDR_RST_DLY:   next_rdata = {6'h00, cfg.rst_dly};
				ADDR_FS_CFG2:   next_rdata = {7'h00, cfg.final_short};
				ADDR_SUP_CFG2:  next_rdata = {7'h00, cfg.stuck_dis};
				ADDR_WINDOW:    next_rdata = {3'h0, cfg.wd_dis, cfg.win_sel};
				ADDR_CHALLENGE: next_rdata = lfsr;
				ADDR_STATUS:    next_rdata = {rst_err, state, dbg_lat, inhibit};
				ADDR_COUNTERS:  next_rdata = {closed, ref_cnt, wd_err};
				default:        next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state <= ST_SELECT;
			cfg <= CFG_RESET;
			powerup <= 1'b1;
			dbg_lat <= 1'b0;
			win_act <= WIN_SEL_RESET;
			lfsr <= LFSR_RESET;
			wd_err <= 4'h0;
			ref_cnt <= 3'h0;
			rst_err <= RST_ERR_RESET;
			tcnt <= 12'h000;
			stk_cnt <= 16'h0000;
			irq_cnt <= 8'h00;
			o_rdata <= 8'h00;
			o_reset_out_n <= 1'b0;
			o_failsafe_out_n <= 1'b0;
			o_irq_out_n <= 1'b1;
			o_regs_on <= 1'b1;
		end else begin
			state <= next_state;
			cfg <= next_cfg;
			powerup <= next_powerup;
			dbg_lat <= next_dbg_lat;
			win_act <= next_win_act;
			lfsr <= next_lfsr;
			wd_err <= next_wd_err;
			ref_cnt <= next_ref_cnt;
			rst_err <= next_rst_err;
			tcnt <= next_tcnt;
			stk_cnt <= next_stk_cnt;
			irq_cnt <= next_irq_cnt;
			o_rdata <= next_rdata;
			o_reset_out_n <= next_reset_n;
			o_failsafe_out_n <= next_fs_n;
			o_irq_out_n <= (next_irq_cnt == 8'h00);
			o_regs_on <= next_regs_on;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	a_reset_pin_state: assert property (
		o_reset_out_n == (state == ST_INIT || state == ST_RUN))
		else $error("reset output disagrees with state");
	a_deep_regs_off: assert property (
		(state == ST_DEEP || state == ST_SLEEP) |-> !o_regs_on && !o_reset_out_n)
		else $error("regulators on in deep fail-safe");
	a_key_off_sleep: assert property (
		(state == ST_DEEP && !key_s) |=> state == ST_SLEEP)
		else $error("key low did not enter sleep");
	a_final_count_deep: assert property (
		(rst_err >= final_val && state != ST_SLEEP) |-> state == ST_DEEP)
		else $error("final reset error count without deep fail-safe");
	a_good_steps_word: assert property (
		(ans_good && state == ST_RUN && !go_reset) |=> lfsr == lfsr_step($past(lfsr)) && tcnt == 12'h000)
		else $error("good answer did not step challenge");
	a_bad_keeps_word: assert property (
		(ans_bad && state == ST_RUN && !go_reset) |=> lfsr == $past(lfsr) && !o_irq_out_n
			&& wd_err == (($past(wd_err) + 4'h2 > WD_ERR_LIMIT) ? WD_ERR_LIMIT : $past(wd_err) + 4'h2))
		else $error("bad answer handling wrong");
	a_closed_is_bad: assert property (
		(ans_hit && closed && wd_err < 4'h4 && !go_reset) |=> !o_irq_out_n
			&& wd_err == $past(wd_err) + 4'h2)
		else $error("closed window access not counted as bad");
	a_delay_cfg_lock: assert property (
		(i_wr && i_addr == ADDR_RST_DLY && state != ST_INIT && state != ST_SLEEP)
			|=> cfg.rst_dly == $past(cfg.rst_dly))
		else $error("reset delay written outside init");
	a_init_fail_count: assert property (
		(state == ST_INIT && (ans_bad || timeout) && !inhibit && rst_err < RST_ERR_MAX)
			|=> rst_err == $past(rst_err) + 3'h1 && !o_reset_out_n)
		else $error("init failure did not assert reset");
	a_window_restart: assert property (
		(state == ST_RUN && ans_hit && i_wr && !go_reset) |=> tcnt == 12'h000)
		else $error("answer write did not restart window");

endmodule : sswd_top
